/* File: src/asqr_responder.v */
// Status and readback responder of the ASCII command interpreter.
// Assumes a decoded command strobe from the parser, a character sink with valid/ready,
// and a flash port whose read data follows its address by one clock.
`timescale 1ns/1ps
`include "asqr_defs.vh"

module asqr_responder #(
    parameter NAX = `ASQR_NAX,
    parameter WW = 32,
    parameter PW = `ASQR_PARAM_WORDS,
    parameter PAW = `ASQR_PARAM_AW
) (
    // Clock and reset.
    input wire i_mclk,
    input wire i_rst_b,
    // Command from the parser.
    input wire i_cmd_valid,
    input wire [3:0] i_cmd_code,
    input wire [1:0] i_mode,
    input wire [1:0] i_axis_sel,
    output reg o_busy,
    output reg o_cmd_invalid,
    // Reply characters.
    output reg o_tx_valid,
    output reg [7:0] o_tx_char,
    input wire i_tx_ready,
    // Axis pins.
    input wire [NAX-1:0] i_lim_pos,
    input wire [NAX-1:0] i_lim_neg,
    input wire [NAX-1:0] i_home,
    // Motion state.
    input wire [NAX-1:0] i_dir_neg,
    input wire [NAX-1:0] i_done_set,
    input wire [NAX-1:0] i_done_clr,
    input wire [NAX-1:0] i_accelerating,
    input wire [NAX*WW-1:0] i_accel,
    input wire i_contour_run,
    input wire [WW-1:0] i_contour_accel,
    input wire [NAX*WW-1:0] i_enc_pos,
    input wire [7:0] i_gpio_dir,
    // Flash default set.
    output reg [PAW-1:0] o_flash_addr,
    input wire [WW-1:0] i_flash_data,
    // Active parameter readback.
    input wire [PAW-1:0] i_param_addr,
    output wire [WW-1:0] o_param_data
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_LEAD = 3'h1;
localparam ST_BODY = 3'h2;
localparam ST_TAIL = 3'h3;
localparam ST_LOAD = 3'h4;

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
function [1:0] lead_len;
    input [3:0] cmd;
    begin
        case (cmd)
            `ASQR_CMD_SINGLE_PEEK, `ASQR_CMD_SINGLE_CLEAR: lead_len = `ASQR_LEN_STATUS_FRAME;
            `ASQR_CMD_ACCEL: lead_len = `ASQR_LEN_PAIR_FRAME; // [R18]
            default: lead_len = `ASQR_LEN_NONE;
        endcase
    end
endfunction

function [1:0] tail_len;
    input [3:0] cmd;
    begin
        case (cmd)
            `ASQR_CMD_SINGLE_PEEK, `ASQR_CMD_SINGLE_CLEAR: tail_len = `ASQR_LEN_STATUS_FRAME;
            `ASQR_CMD_ACCEL: tail_len = `ASQR_LEN_PAIR_FRAME; // [R18]
            default: tail_len = `ASQR_LEN_LF_ONLY;
        endcase
    end
endfunction

function [3:0] item_len;
    input [3:0] cmd;
    begin
        case (cmd)
            `ASQR_CMD_LIMIT_MAP: item_len = `ASQR_LEN_LIMIT;
            `ASQR_CMD_IO_DIR: item_len = `ASQR_LEN_IODIR;
            `ASQR_CMD_ACCEL, `ASQR_CMD_ENCODER: item_len = `ASQR_LEN_WORD;
            default: item_len = `ASQR_LEN_STATUS;
        endcase
    end
endfunction

function [7:0] hexc;
    input [3:0] nib;
    begin
        if (nib < 4'ha)
            hexc = `ASQR_CH_0 + {4'h0, nib};
        else
            hexc = `ASQR_CH_A_MINUS_10 + {4'h0, nib};
    end
endfunction

// Nibble of a word counted from the most significant end.
function [3:0] nib_of;
    input [WW-1:0] w;
    input [3:0] pos;
    input [3:0] len;
    reg [3:0] k;
    begin
        k = len - 4'h1 - pos;
        nib_of = w[k*4 +: 4];
    end
endfunction

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
reg [3*NAX-1:0] pin_meta_r;
reg [3*NAX-1:0] pin_sync_r;
wire [NAX-1:0] lim_pos_s = pin_sync_r[NAX-1:0];
wire [NAX-1:0] lim_neg_s = pin_sync_r[2*NAX-1:NAX];
wire [NAX-1:0] home_s = pin_sync_r[3*NAX-1:2*NAX];

always @(posedge i_mclk)
begin
    pin_meta_r <= {i_home, i_lim_neg, i_lim_pos};
    pin_sync_r <= pin_meta_r;
end

// ----------------------------------------------------------------
// Command acceptance
// ----------------------------------------------------------------
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [3:0] cmd_r;
reg [1:0] axis_r;
reg all_r;
reg [3:0] pos_r;
reg [1:0] item_r;
reg [NAX-1:0] done_r;
reg [NAX-1:0] done_snap_r;

wire multi_mode = (i_mode == `ASQR_MODE_ALL) || (i_mode == `ASQR_MODE_MULTI);
wire take = i_cmd_valid && (state_r == ST_IDLE); // [R24]
reg cmd_ok;

always @*
begin
    cmd_ok = 1'b0;
    if (i_mode != `ASQR_MODE_CONTOUR_DEF) // [R23]
    begin
        case (i_cmd_code)
            `ASQR_CMD_ALL_PEEK, `ASQR_CMD_ALL_CLEAR: cmd_ok = multi_mode; // [R13]
            `ASQR_CMD_SINGLE_PEEK, `ASQR_CMD_SINGLE_CLEAR: cmd_ok = !multi_mode;
            `ASQR_CMD_LIMIT_MAP, `ASQR_CMD_IO_DIR, `ASQR_CMD_ACCEL: cmd_ok = 1'b1; // [R6]
            `ASQR_CMD_ENCODER, `ASQR_CMD_LOAD_USER, `ASQR_CMD_LOAD_FACTORY: cmd_ok = 1'b1;
            default: cmd_ok = 1'b0;
        endcase
    end
end

wire accept = take && cmd_ok;
wire is_load = (i_cmd_code == `ASQR_CMD_LOAD_USER) || (i_cmd_code == `ASQR_CMD_LOAD_FACTORY);

// ----------------------------------------------------------------
// Done flags
// ----------------------------------------------------------------
// The reply uses the snapshot, so clearing at acceptance still reports the old flags.
// A done-set arriving in the clearing cycle survives.
reg [NAX-1:0] done_clr_cmd;

always @*
begin
    done_clr_cmd = {NAX{1'b0}};
    if (accept && i_cmd_code == `ASQR_CMD_SINGLE_CLEAR)
        done_clr_cmd[i_axis_sel] = 1'b1; // [R7]
    else if (accept && i_cmd_code == `ASQR_CMD_ALL_CLEAR)
        done_clr_cmd = {NAX{1'b1}}; // [R14]
end

always @(posedge i_mclk)
begin
    if (!i_rst_b)
        done_r <= {NAX{1'b0}};
    else
        done_r <= (done_r & ~(done_clr_cmd | i_done_clr)) | i_done_set; // [R10] [R2] [R22]
end

always @(posedge i_mclk)
begin
    if (!i_rst_b)
        done_snap_r <= {NAX{1'b0}};
    else if (accept)
        done_snap_r <= done_r;
end

// ----------------------------------------------------------------
// Reply character
// ----------------------------------------------------------------
wire [1:0] axis_cur = all_r ? item_r : axis_r;
wire last_item = !all_r || (item_r == NAX - 1);
wire [3:0] ilen = item_len(cmd_r);
wire [WW-1:0] accel_sel = i_accel[axis_cur*WW +: WW];
wire [WW-1:0] enc_sel = i_enc_pos[axis_cur*WW +: WW];
wire [15:0] limit_map = {`ASQR_LIM_FILL, lim_pos_s, `ASQR_LIM_FILL, lim_neg_s}; // [R3] [R4] [R5]
reg [WW-1:0] accel_val;
reg [7:0] body_ch;
reg [7:0] ch_nxt;

always @*
begin
    if (i_contour_run)
        accel_val = i_contour_accel; // [R17]
    else if (i_accelerating[axis_cur])
        accel_val = accel_sel;
    else
        accel_val = {WW{1'b0}}; // [R16]
end

always @*
begin
    body_ch = `ASQR_CH_COMMA; // [R1]
    if (pos_r < ilen)
    begin
        case (cmd_r)
            `ASQR_CMD_LIMIT_MAP:
                body_ch = hexc(nib_of({{(WW-16){1'b0}}, limit_map}, pos_r, ilen));
            `ASQR_CMD_IO_DIR:
                body_ch = hexc(nib_of({{(WW-8){1'b0}}, i_gpio_dir}, pos_r, ilen)); // [R15]
            `ASQR_CMD_ACCEL:
                body_ch = hexc(nib_of(accel_val, pos_r, ilen));
            `ASQR_CMD_ENCODER:
                body_ch = hexc(nib_of(enc_sel, pos_r, ilen)); // [R21]
            default:
            begin
                case (pos_r)
                    `ASQR_POS_DIR:
                        body_ch = i_dir_neg[axis_cur] ? `ASQR_CH_M : `ASQR_CH_P; // [R9]
                    `ASQR_POS_DONE:
                        body_ch = done_snap_r[axis_cur] ? `ASQR_CH_D : `ASQR_CH_N; // [R10]
                    `ASQR_POS_LIMIT:
                        body_ch = (i_dir_neg[axis_cur] ? lim_neg_s[axis_cur] :
                                   lim_pos_s[axis_cur]) ? `ASQR_CH_L : `ASQR_CH_N; // [R11]
                    default:
                        body_ch = home_s[axis_cur] ? `ASQR_CH_H : `ASQR_CH_N; // [R12]
                endcase
            end
        endcase
    end
end

always @*
begin
    if (state_r == ST_BODY)
        ch_nxt = body_ch;
    else if (pos_r == 4'h0)
        ch_nxt = `ASQR_CH_LF; // [R8]
    else
        ch_nxt = `ASQR_CH_CR;
end

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
wire send_ok = !o_tx_valid || i_tx_ready;
wire sending = (state_r == ST_LEAD) || (state_r == ST_BODY) || (state_r == ST_TAIL);
wire step = sending && send_ok;
wire [3:0] body_end = last_item ? ilen - 4'h1 : ilen;
reg [PAW:0] load_cnt_r;
reg load_factory_r;
reg load_we_r;
reg [PAW-1:0] load_waddr_r;
wire load_last = (load_cnt_r == PW - 1);

always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE:
            if (accept && is_load)
                state_nxt = ST_LOAD;
            else if (accept)
                state_nxt = (lead_len(i_cmd_code) != `ASQR_LEN_NONE) ? ST_LEAD : ST_BODY;
        ST_LEAD:
            if (step && pos_r == {2'h0, lead_len(cmd_r)} - 4'h1)
                state_nxt = ST_BODY;
        ST_BODY:
            if (step && last_item && pos_r == body_end)
                state_nxt = ST_TAIL;
        ST_TAIL:
            if (step && pos_r == {2'h0, tail_len(cmd_r)} - 4'h1)
                state_nxt = ST_IDLE;
        ST_LOAD:
            if (load_last)
                state_nxt = ST_IDLE;
        default:
            state_nxt = ST_IDLE;
    endcase
end

always @(posedge i_mclk)
begin
    if (!i_rst_b)
    begin
        state_r <= ST_IDLE;
        cmd_r <= `ASQR_CMD_NONE;
        axis_r <= 2'h0;
        all_r <= 1'b0;
        pos_r <= 4'h0;
        item_r <= 2'h0;
        o_tx_valid <= 1'b0;
        o_tx_char <= 8'h00;
        o_busy <= 1'b0;
        o_cmd_invalid <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        o_busy <= (state_nxt != ST_IDLE);
        o_cmd_invalid <= take && !cmd_ok; // [R23]
        if (accept)
        begin
            cmd_r <= i_cmd_code;
            axis_r <= i_axis_sel;
            all_r <= multi_mode && (i_cmd_code != `ASQR_CMD_LIMIT_MAP) &&
                     (i_cmd_code != `ASQR_CMD_IO_DIR);
            pos_r <= 4'h0;
            item_r <= 2'h0;
        end
        if (step)
        begin
            o_tx_valid <= 1'b1;
            o_tx_char <= ch_nxt;
            if (state_nxt != state_r)
                pos_r <= 4'h0;
            else if (state_r == ST_BODY && pos_r == ilen)
            begin
                pos_r <= 4'h0;
                item_r <= item_r + 2'h1;
            end
            else
                pos_r <= pos_r + 4'h1;
        end
        else if (i_tx_ready)
            o_tx_valid <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Parameter set loading
// ----------------------------------------------------------------
// Flash data arrive one clock after the address, so the write trails the address.
always @(posedge i_mclk)
begin
    if (!i_rst_b)
    begin
        load_cnt_r <= {(PAW+1){1'b0}};
        load_factory_r <= 1'b0;
        load_we_r <= 1'b0;
        load_waddr_r <= {PAW{1'b0}};
        o_flash_addr <= {PAW{1'b0}};
    end
    else
    begin
        load_we_r <= (state_r == ST_LOAD);
        load_waddr_r <= o_flash_addr;
        if (accept && is_load)
        begin
            load_factory_r <= (i_cmd_code == `ASQR_CMD_LOAD_FACTORY);
            load_cnt_r <= {(PAW+1){1'b0}};
            o_flash_addr <= {PAW{1'b0}};
        end
        else if (state_r == ST_LOAD)
        begin
            load_cnt_r <= load_cnt_r + 1'b1;
            o_flash_addr <= load_cnt_r[PAW-1:0] + 1'b1;
        end
    end
end

asqr_param_mem #(
    .DW(WW),
    .AW(PAW)
) u_param_mem (
    .i_mclk(i_mclk),
    .i_we(load_we_r),
    .i_waddr(load_waddr_r),
    .i_wdata(load_factory_r ? `ASQR_FACTORY_WORD : i_flash_data), // [R19] [R20]
    .i_raddr(i_param_addr),
    .o_rdata(o_param_data)
);

endmodule

/* File: inc/asqr_defs.vh */
// Constants for the axis status and readback responder.
// Assumes one 25 MHz clock and an upstream parser that hands over one decoded command at a time.
//
// How it works
// [R1] All-axes peek status: one 4-character field per axis, comma separated.
// [R2] All-axes peek status leaves the latched done flags untouched.
// [R3] Limit map bit is 1 when its sensor input is high, 0 when low.
// [R4] Positive limits of axes 3..0 sit in bits 11..8; bits 15..12 read high.
// [R5] Negative limits of axes 3..0 sit in bits 3..0; bits 7..4 read high.
// [R6] Limit query answers at once in single, all-axes and multi-axis modes.
// [R7] Single-axis clear status reports the axis, then clears its done flag.
// [R8] Single-axis status reply is LF CR CR, four characters, LF CR CR.
// [R9] Character 4 is P when moving positive, M when moving negative.
// [R10] Character 5 is D after a done-set; back to N after a clear.
// [R11] Character 6 is L while the limit in the shown direction is active.
// [R12] Character 7 is H while the home input is active, else N.
// [R13] All-axes clear status is accepted only in multi-axis modes.
// [R14] All-axes clear status clears every axis done flag after answering.
// [R15] Direction report gives the general I/O input/output map in hex.
// [R16] Acceleration report is zero when stopped or cruising.
// [R17] During a contour the acceleration report gives the lead-in value.
// [R18] Acceleration reply is wrapped in LF CR pairs front and back.
// [R19] Load user defaults copies the flash default set into the active set.
// [R20] Load factory defaults copies the factory set into the active set.
// [R21] Encoder readback gives the count of the axis, or of all axes.
// [R22] Single-axis peek status reports like the clear request but clears nothing.
// [R23] Every command here is refused without reply in contour-definition mode.
// [R24] Host picks the mode first and waits for the terminator before the next query.
`ifndef ASQR_DEFS_VH
`define ASQR_DEFS_VH

`define ASQR_NAX 4

// Addressing modes.
`define ASQR_MODE_SINGLE 2'h0
`define ASQR_MODE_ALL 2'h1
`define ASQR_MODE_MULTI 2'h2
`define ASQR_MODE_CONTOUR_DEF 2'h3

// Command codes.
`define ASQR_CMD_NONE 4'h0
`define ASQR_CMD_ALL_PEEK 4'h1
`define ASQR_CMD_SINGLE_PEEK 4'h2
`define ASQR_CMD_LIMIT_MAP 4'h3
`define ASQR_CMD_SINGLE_CLEAR 4'h4
`define ASQR_CMD_ALL_CLEAR 4'h5
`define ASQR_CMD_IO_DIR 4'h6
`define ASQR_CMD_ACCEL 4'h7
`define ASQR_CMD_LOAD_USER 4'h8
`define ASQR_CMD_LOAD_FACTORY 4'h9
`define ASQR_CMD_ENCODER 4'ha

// Characters.
`define ASQR_CH_LF 8'h0a
`define ASQR_CH_CR 8'h0d
`define ASQR_CH_COMMA 8'h2c
`define ASQR_CH_P 8'h50
`define ASQR_CH_M 8'h4d
`define ASQR_CH_D 8'h44
`define ASQR_CH_N 8'h4e
`define ASQR_CH_L 8'h4c
`define ASQR_CH_H 8'h48
`define ASQR_CH_0 8'h30
`define ASQR_CH_A_MINUS_10 8'h57

// Limit map filler nibble.
`define ASQR_LIM_FILL 4'hf

// Reply shapes: frame lengths and field widths in characters.
`define ASQR_LEN_STATUS_FRAME 2'h3
`define ASQR_LEN_PAIR_FRAME 2'h2
`define ASQR_LEN_LF_ONLY 2'h1
`define ASQR_LEN_NONE 2'h0
`define ASQR_LEN_STATUS 4'h4
`define ASQR_LEN_LIMIT 4'h4
`define ASQR_LEN_IODIR 4'h2
`define ASQR_LEN_WORD 4'h8

// Status field character positions.
`define ASQR_POS_DIR 4'h0
`define ASQR_POS_DONE 4'h1
`define ASQR_POS_LIMIT 4'h2

// Parameter set defaults.
`define ASQR_PARAM_WORDS 16
`define ASQR_PARAM_AW 4
`define ASQR_FACTORY_WORD 32'h0000_0000

`endif

/* File: src/asqr_param_mem.v */
// Active parameter set storage: one write port, one read port with registered data.
// Assumes a single clock; a read of the word being written returns the old word.
`timescale 1ns/1ps

module asqr_param_mem #(
    parameter DW = 32,
    parameter AW = 4
) (
    // Clock.
    input wire i_mclk,
    // Write port.
    input wire i_we,
    input wire [AW-1:0] i_waddr,
    input wire [DW-1:0] i_wdata,
    // Read port.
    input wire [AW-1:0] i_raddr,
    output reg [DW-1:0] o_rdata
);

reg [DW-1:0] mem_r [0:(1<<AW)-1];

always @(posedge i_mclk)
begin
    if (i_we)
    begin
        mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
end

endmodule

/* File: bench/asqr_responder_properties.sv */
// Concurrent checks on the command and reply ports of the responder.
// Assumes the single-clock responder; attached by the bind after the module.
`timescale 1ns/1ps
`include "asqr_defs.vh"

module asqr_props (
    // Clock and reset.
    input wire i_mclk,
    input wire i_rst_b,
    // Command port.
    input wire i_cmd_valid,
    input wire [3:0] i_cmd_code,
    input wire [1:0] i_mode,
    input wire o_busy,
    input wire o_cmd_invalid,
    // Reply port.
    input wire o_tx_valid,
    input wire [7:0] o_tx_char,
    input wire i_tx_ready
);
    // --------
    // Checks
    // --------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    wire acc = i_cmd_valid && !o_busy && !o_tx_valid;
    wire live = i_mode != `ASQR_MODE_CONTOUR_DEF;

    a_char_hold: assert property (
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_char))
        else $error("reply character changed before it was taken");
    a_defmode_refuse: assert property (
        acc && !live |=> o_cmd_invalid && !o_tx_valid ##1 !o_tx_valid)
        else $error("command in definition mode was not refused");
    a_single_frame: assert property (
        acc && i_mode == `ASQR_MODE_SINGLE && i_cmd_code == `ASQR_CMD_SINGLE_PEEK
        |=> o_busy && !o_tx_valid ##1 (o_tx_valid && o_tx_char == `ASQR_CH_LF))
        else $error("single status reply did not open with line feed");
    a_clear_all_mode: assert property (
        acc && i_mode == `ASQR_MODE_SINGLE && i_cmd_code == `ASQR_CMD_ALL_CLEAR
        |=> o_cmd_invalid && !o_busy)
        else $error("all-axes clear accepted in single mode");
    a_limit_accept: assert property (
        acc && live && i_cmd_code == `ASQR_CMD_LIMIT_MAP
        |=> o_busy ##1 (o_tx_valid && o_tx_char == 8'h66))
        else $error("limit map not answered with leading f");
    a_invalid_pulse: assert property (
        $rose(o_cmd_invalid) |=> !o_cmd_invalid)
        else $error("invalid flag longer than one cycle");
    a_load_silent: assert property (
        acc && live && (i_cmd_code == `ASQR_CMD_LOAD_USER || i_cmd_code == `ASQR_CMD_LOAD_FACTORY)
        |=> (o_busy && !o_tx_valid) [*8])
        else $error("parameter load produced a reply or ended early");
    a_busy_ends: assert property (
        $rose(o_busy) |-> ##[1:300] !o_busy)
        else $error("busy did not end in time");
    a_accel_frame: assert property (
        acc && live && i_cmd_code == `ASQR_CMD_ACCEL
        |=> o_busy ##1 (o_tx_valid && o_tx_char == `ASQR_CH_LF))
        else $error("acceleration reply did not open with line feed");

    c_single_peek: cover property (acc && i_cmd_code == `ASQR_CMD_SINGLE_PEEK);
    c_all_clear: cover property (acc && i_cmd_code == `ASQR_CMD_ALL_CLEAR && live);
    c_stall: cover property (o_tx_valid && !i_tx_ready ##1 o_tx_valid && i_tx_ready);
endmodule

bind asqr_responder asqr_props u_props (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_cmd_valid(i_cmd_valid),
    .i_cmd_code(i_cmd_code),
    .i_mode(i_mode),
    .o_busy(o_busy),
    .o_cmd_invalid(o_cmd_invalid),
    .o_tx_valid(o_tx_valid),
    .o_tx_char(o_tx_char),
    .i_tx_ready(i_tx_ready)
);

/* File: bench/asqr_host_sink.sv */
// Host-side model that takes the reply characters and records them.
// Assumes the responder's valid/ready reply port on the same clock.
`timescale 1ns/1ps

module asqr_host_sink (
    // Clock.
    input wire i_mclk,
    // Reply characters.
    input wire i_tx_valid,
    input wire [7:0] i_tx_char,
    output reg o_tx_ready,
    // Pacing.
    input wire i_slow
);
    logic [7:0] buf_r [0:63];
    int n;
    initial
    begin
        o_tx_ready = 1'b1;
        n = 0;
    end
    // A slow host drops ready every other cycle, so each character must survive a stall.
    always @(posedge i_mclk)
    begin
        if (i_tx_valid && o_tx_ready && n < 64)
        begin
            buf_r[n] <= i_tx_char;
            n <= n + 1;
        end
        o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
    end
endmodule

/* File: bench/test_axis_status_query_responder.sv */
// Self-checking bench for the axis status and readback responder.
// Assumes the host sink model; a flash stand-in with one cycle of latency lives here.
`timescale 1ns/1ps
`include "asqr_defs.vh"

module test_axis_status_query_responder;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_cmd_valid = 1'b0;
    logic [3:0] i_cmd_code = 4'h0;
    logic [1:0] i_mode = 2'h0;
    logic [1:0] i_axis_sel = 2'h0;
    logic [3:0] i_lim_pos = 4'h0, i_lim_neg = 4'h0, i_home = 4'h0, i_dir_neg = 4'h0;
    logic [3:0] i_done_set = 4'h0, i_done_clr = 4'h0, i_accelerating = 4'h0;
    logic [127:0] i_accel = 128'h0, i_enc_pos = 128'h0;
    logic i_contour_run = 1'b0, i_slow = 1'b0, inv;
    logic [31:0] i_contour_accel = 32'h0, i_flash_data = 32'h0;
    logic [7:0] i_gpio_dir = 8'h0;
    logic [3:0] i_param_addr = 4'h0;
    wire o_busy, o_cmd_invalid, o_tx_valid, tx_ready;
    wire [7:0] o_tx_char;
    wire [3:0] o_flash_addr;
    wire [31:0] o_param_data;
    int n_fail = 0, checks = 0;

    asqr_responder uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cmd_valid(i_cmd_valid),
        .i_cmd_code(i_cmd_code), .i_mode(i_mode), .i_axis_sel(i_axis_sel), .o_busy(o_busy),
        .o_cmd_invalid(o_cmd_invalid), .o_tx_valid(o_tx_valid), .o_tx_char(o_tx_char),
        .i_tx_ready(tx_ready), .i_lim_pos(i_lim_pos), .i_lim_neg(i_lim_neg), .i_home(i_home),
        .i_dir_neg(i_dir_neg), .i_done_set(i_done_set), .i_done_clr(i_done_clr),
        .i_accelerating(i_accelerating), .i_accel(i_accel), .i_contour_run(i_contour_run),
        .i_contour_accel(i_contour_accel), .i_enc_pos(i_enc_pos), .i_gpio_dir(i_gpio_dir),
        .o_flash_addr(o_flash_addr), .i_flash_data(i_flash_data),
        .i_param_addr(i_param_addr), .o_param_data(o_param_data));
    asqr_host_sink host (.i_mclk(i_mclk), .i_tx_valid(o_tx_valid), .i_tx_char(o_tx_char),
        .o_tx_ready(tx_ready), .i_slow(i_slow));

    initial
        forever #20 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
        i_flash_data <= {28'h5a00000, o_flash_addr};

    // --------
    // Tasks
    // --------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic issue(input logic [3:0] code);
        int k;
        host.n = 0;
        @(posedge i_mclk);
        i_cmd_valid <= 1'b1;
        i_cmd_code <= code;
        @(posedge i_mclk);
        i_cmd_valid <= 1'b0;
        #1 inv = o_cmd_invalid;
        k = 0;
        while ((o_busy || o_tx_valid) && k < 300)
        begin
            @(posedge i_mclk);
            #1 k++;
        end
        if (k == 300)
        begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic reply_is(input string exp);
        chk("reply length", host.n, exp.len());
        for (int i = 0; i < exp.len(); i++)
            chk("reply char", {24'h0, host.buf_r[i]}, {24'h0, exp[i]});
    endtask
    task automatic refused(input logic [3:0] code);
        issue(code);
        chk("refusal flag", {31'h0, inv}, 32'h1);
        chk("refused reply length", host.n, 32'h0);
    endtask
    task automatic read_param(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_param_addr <= a;
        repeat (2) @(posedge i_mclk);
        #1 chk("parameter word", o_param_data, exp);
    endtask

    // --------
    // Sequence
    // --------
    initial
    begin
        repeat (5) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(posedge i_mclk);
        #1 chk("busy after reset", {31'h0, o_busy}, 32'h0);
        chk("valid after reset", {31'h0, o_tx_valid}, 32'h0);
        chk("flash address after reset", {28'h0, o_flash_addr}, 32'h0);
        $display("test reset done");
        @(posedge i_mclk);
        i_axis_sel <= 2'h1;
        i_lim_pos <= 4'h2;
        i_home <= 4'h2;
        i_done_set <= 4'h2;
        @(posedge i_mclk);
        i_done_set <= 4'h0;
        repeat (3) @(posedge i_mclk);
        issue(`ASQR_CMD_SINGLE_PEEK);
        reply_is("\n\r\rPDLH\n\r\r");
        issue(`ASQR_CMD_SINGLE_CLEAR);
        reply_is("\n\r\rPDLH\n\r\r");
        @(posedge i_mclk);
        i_dir_neg <= 4'h2;
        i_home <= 4'h0;
        i_slow <= 1'b1;
        repeat (3) @(posedge i_mclk);
        issue(`ASQR_CMD_SINGLE_PEEK);
        reply_is("\n\r\rMNNN\n\r\r");
        @(posedge i_mclk);
        i_done_set <= 4'h2;
        @(posedge i_mclk);
        i_done_set <= 4'h0;
        i_done_clr <= 4'h2;
        @(posedge i_mclk);
        i_done_clr <= 4'h0;
        i_slow <= 1'b0;
        issue(`ASQR_CMD_SINGLE_PEEK);
        reply_is("\n\r\rMNNN\n\r\r");
        refused(`ASQR_CMD_ALL_CLEAR);
        $display("test single status done");
        @(posedge i_mclk);
        i_lim_pos <= 4'h8;
        i_lim_neg <= 4'h1;
        repeat (3) @(posedge i_mclk);
        for (int m = 0; m < 3; m++)
        begin
            @(posedge i_mclk);
            i_mode <= m[1:0];
            issue(`ASQR_CMD_LIMIT_MAP);
            reply_is("f8f1\n");
        end
        $display("test limit map done");
        @(posedge i_mclk);
        i_mode <= `ASQR_MODE_ALL;
        i_lim_pos <= 4'h0;
        i_lim_neg <= 4'h8;
        i_dir_neg <= 4'ha;
        i_home <= 4'h1;
        i_done_set <= 4'h4;
        @(posedge i_mclk);
        i_done_set <= 4'h0;
        i_slow <= 1'b1;
        repeat (3) @(posedge i_mclk);
        issue(`ASQR_CMD_ALL_PEEK);
        reply_is("PNNH,MNNN,PDNN,MNLN\n");
        issue(`ASQR_CMD_ALL_PEEK);
        reply_is("PNNH,MNNN,PDNN,MNLN\n");
        issue(`ASQR_CMD_ALL_CLEAR);
        reply_is("PNNH,MNNN,PDNN,MNLN\n");
        issue(`ASQR_CMD_ALL_PEEK);
        reply_is("PNNH,MNNN,PNNN,MNLN\n");
        $display("test all status done");
        @(posedge i_mclk);
        i_mode <= `ASQR_MODE_SINGLE;
        i_slow <= 1'b0;
        i_gpio_dir <= 8'h0f;
        i_accelerating <= 4'h2;
        i_accel <= {32'h0, 32'h0, 32'h00001234, 32'h0000ffff};
        i_enc_pos <= {32'h0, 32'h0, 32'h0001e240, 32'h00000007};
        issue(`ASQR_CMD_IO_DIR);
        reply_is("0f\n");
        issue(`ASQR_CMD_ACCEL);
        reply_is("\n\r00001234\n\r");
        issue(`ASQR_CMD_ENCODER);
        reply_is("0001e240\n");
        @(posedge i_mclk);
        i_mode <= `ASQR_MODE_MULTI;
        refused(`ASQR_CMD_SINGLE_PEEK);
        issue(`ASQR_CMD_ACCEL);
        reply_is("\n\r00000000,00001234,00000000,00000000\n\r");
        issue(`ASQR_CMD_ENCODER);
        reply_is("00000007,0001e240,00000000,00000000\n");
        @(posedge i_mclk);
        i_mode <= `ASQR_MODE_SINGLE;
        i_accelerating <= 4'h0;
        i_contour_run <= 1'b1;
        i_contour_accel <= 32'h0000abcd;
        issue(`ASQR_CMD_ACCEL);
        reply_is("\n\r0000abcd\n\r");
        $display("test readback done");
        @(posedge i_mclk);
        i_mode <= `ASQR_MODE_CONTOUR_DEF;
        for (int c = 1; c <= 10; c++)
            refused(c[3:0]);
        $display("test definition mode done");
        @(posedge i_mclk);
        i_mode <= `ASQR_MODE_SINGLE;
        issue(`ASQR_CMD_LOAD_USER);
        chk("load reply length", host.n, 32'h0);
        for (int a = 0; a < 16; a += 5)
            read_param(a[3:0], {28'h5a00000, a[3:0]});
        issue(`ASQR_CMD_LOAD_FACTORY);
        for (int a = 0; a < 16; a += 5)
            read_param(a[3:0], `ASQR_FACTORY_WORD);
        $display("test defaults done");
        wrap_up();
    end
endmodule
